// ==== eep_pkg.sv ====
// Purpose: shared constants and types for the two-wire eeprom link
// Assumes: both ends compile against this package
// Notes:   type code value is arbitrary
package eep_pkg;
	localparam int          ADDR_W      = 13;
	localparam int          MEM_DEPTH   = 8192;
	localparam int          BYTE_W      = 8;
	localparam logic [3:0]  BIT_ACK     = 4'h8;
	localparam logic [3:0]  TYPE_CODE   = 4'h6; // arbitrary device-type code
	localparam int          CODE_HI     = 7;
	localparam int          CODE_LO     = 4;
	localparam int          CS_HI       = 3;
	localparam int          CS_LO       = 1;
	localparam int          RNW_BIT     = 0;
	localparam int          AH_USED     = 5;
	localparam logic [2:0]  AH_PAD      = 3'h0;
	// pin vector of the device synchroniser
	localparam int          PIN_W       = 6;
	localparam int          P_SCL       = 0;
	localparam int          P_SDA       = 1;
	localparam int          P_WP        = 2;
	localparam int          P_CA_LO     = 3;
	localparam int          P_CA_HI     = 5;
	// host bit timing: four quarters per bit
	localparam int          CLK_SYS_NS  = 100;
	localparam int          BIT_TIME_NS = 10000;
	localparam int          QTRS        = 4;
	localparam logic [1:0]  Q_LOW       = 2'h0;
	localparam logic [1:0]  Q_RISE      = 2'h1;
	localparam logic [1:0]  Q_MID       = 2'h2;
	localparam logic [1:0]  Q_FALL      = 2'h3;
	localparam int          WR_CYC_DEF  = 1000;
	typedef enum logic [1:0] {
		OP_WRITE   = 2'b00,
		OP_POLL    = 2'b01,
		OP_RD_CUR  = 2'b10,
		OP_RD_RAND = 2'b11
	} eep_op_e;
endpackage

// ==== eep_link_if.sv ====
// Purpose: two-wire link between controller and eeprom
// Assumes: data line is open drain with a pull-up
// Notes:   wire level is resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface eep_link_if;
	logic scl;
	logic host_sda_oe;
	logic host_sda_o;
	logic dev_sda_oe;
	logic dev_sda_o;
	logic sda;
	// pull-up wins unless a driver pulls low
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output scl, output host_sda_oe, output host_sda_o, input sda);
	modport dev  (input scl, input sda, output dev_sda_oe, output dev_sda_o);
endinterface
`default_nettype wire

// ==== eep_dev.sv ====
// Purpose: eeprom target end: polling, reads, pointer, select, protect
// Assumes: link_clk runs free and much faster than scl
// Notes:   one byte per write command is committed
//
// Summary of operation
// - no control byte acked while write runs
// - write cycle starts at the ending Stop
// - controller repeats Start and write control
// - ack polling byte once write completes
// - read selected by control bit set to one
// - pointer holds last address plus one
// - read control acked, then pointer byte sent
// - write control plus address only loads pointer
// - after random read pointer follows sent byte
// - each master ack sends next byte
// - pointer wraps from top to zero
// - respond only if three select bits match
// - data line only pulled low or released
// - data change while clock high is Start/Stop
// - protect low allows reads and writes
// - protect high blocks writes, reads work
// - control byte: code, select bits, read bit
// - address high byte first, thirteen bits used
// - release line after master withholds ack
`timescale 1ns/1ps
`default_nettype none
module eep_dev import eep_pkg::*; #(
	parameter int WR_CYC = WR_CYC_DEF
) (
	eep_link_if.dev         link,
	input  wire logic       link_clk,
	input  wire logic       link_rst,
	input  wire logic       chip_addr_bit0,
	input  wire logic       chip_addr_bit1,
	input  wire logic       chip_addr_bit2,
	input  wire logic       write_protect_pin,
	output logic            wr_busy_q
);
	localparam int BUSY_W = $clog2(WR_CYC + 1);

	typedef enum logic [2:0] {
		D_IDLE  = 3'b000,
		D_CTRL  = 3'b001,
		D_AH    = 3'b010,
		D_AL    = 3'b011,
		D_WDATA = 3'b100,
		D_READ  = 3'b101
	} eep_dst_e;

	// ***********************************
	// pin synchronisers
	// ***********************************
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q, p_q, f_d;
	logic             scl_f, sda_f, scl_p, sda_p;
	logic             start_ev, stop_ev, rise_ev, fall_ev;

	// a change counts once stages two and three agree
	always_comb begin
		f_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & f_q);
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			f_q  <= '1;
			p_q  <= '1;
		end else begin
			s1_q <= {chip_addr_bit2, chip_addr_bit1, chip_addr_bit0,
				write_protect_pin, link.sda, link.scl};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q  <= f_d;
			p_q  <= f_q;
		end
	end

	assign scl_f    = f_q[P_SCL];
	assign sda_f    = f_q[P_SDA];
	assign scl_p    = p_q[P_SCL];
	assign sda_p    = p_q[P_SDA];
	assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
	assign stop_ev  = scl_f & scl_p & ~sda_p & sda_f;
	assign rise_ev  = scl_f & ~scl_p;
	assign fall_ev  = ~scl_f & scl_p;

	// ***********************************
	// protocol engine
	// ***********************************
	eep_dst_e                st_q, st_d;
	logic [3:0]              bitn_q, bitn_d;
	logic                    ackph_q, ackph_d;
	logic                    ackin_q, ackin_d;
	logic                    rnw_q, rnw_d;
	logic [BYTE_W-1:0]       shr_q, shr_d;
	logic                    oe_q, oe_d;
	logic [ADDR_W-1:0]       ptr_q, ptr_d;
	logic [AH_USED-1:0]      ahi_q, ahi_d;
	logic [BYTE_W-1:0]       wbuf_q, wbuf_d;
	logic [ADDR_W-1:0]       waddr_q, waddr_d;
	logic                    wpend_q, wpend_d;
	logic [BUSY_W-1:0]       busy_q, busy_d;
	logic                    mem_we;
	logic [BYTE_W-1:0]       mem_q [MEM_DEPTH];
	logic [BYTE_W-1:0]       rd_byte;

	assign rd_byte = mem_q[ptr_q];

	always_comb begin
		st_d    = st_q;
		bitn_d  = bitn_q;
		ackph_d = ackph_q;
		ackin_d = ackin_q;
		rnw_d   = rnw_q;
		shr_d   = shr_q;
		oe_d    = oe_q;
		ptr_d   = ptr_q;
		ahi_d   = ahi_q;
		wbuf_d  = wbuf_q;
		waddr_d = waddr_q;
		wpend_d = wpend_q;
		mem_we  = 1'b0;
		busy_d  = (busy_q != '0) ? busy_q - BUSY_W'(1) : busy_q;
		if (start_ev) begin
			// a Start after the address ends the write, pointer kept
			st_d    = D_CTRL;
			bitn_d  = '0;
			ackph_d = 1'b0;
			oe_d    = 1'b0;
			wpend_d = 1'b0;
		end else if (stop_ev) begin
			// protect is sampled here; a protected write never goes busy
			if (wpend_q && !f_q[P_WP]) begin
				mem_we = 1'b1;
				busy_d = BUSY_W'(WR_CYC);
			end
			wpend_d = 1'b0;
			st_d    = D_IDLE;
			oe_d    = 1'b0;
		end else if (st_q != D_IDLE) begin
			if (rise_ev) begin
				if (bitn_q < BIT_ACK) begin
					shr_d  = {shr_q[BYTE_W-2:0], sda_f};
					bitn_d = bitn_q + 4'h1;
				end else begin
					ackin_d = sda_f;
				end
			end else if (fall_ev) begin
				if (bitn_q < BIT_ACK) begin
					// never drive high, only pull low or let go
					oe_d = (st_q == D_READ) & ~shr_q[BYTE_W-1];
				end else if (!ackph_q) begin
					ackph_d = 1'b1;
					case (st_q)
						D_CTRL: begin
							if (shr_q[CODE_HI:CODE_LO] == TYPE_CODE
								&& shr_q[CS_HI:CS_LO] == f_q[P_CA_HI:P_CA_LO]
								&& busy_q == '0) begin
								oe_d  = 1'b1;
								rnw_d = shr_q[RNW_BIT];
							end else begin
								oe_d = 1'b0;
								st_d = D_IDLE;
							end
						end
						D_AH: begin
							// top three bits are don't care
							ahi_d = shr_q[AH_USED-1:0];
							oe_d  = 1'b1;
						end
						D_AL: begin
							ptr_d = {ahi_q, shr_q};
							oe_d  = 1'b1;
						end
						D_WDATA: begin
							wbuf_d  = shr_q;
							waddr_d = ptr_q;
							wpend_d = 1'b1;
							ptr_d   = ptr_q + ADDR_W'(1);
							oe_d    = 1'b1;
						end
						D_READ: begin
							// natural 13-bit wrap takes the top back to zero
							oe_d  = 1'b0;
							ptr_d = ptr_q + ADDR_W'(1);
						end
						default: begin
							oe_d = 1'b0;
						end
					endcase
				end else begin
					ackph_d = 1'b0;
					bitn_d  = '0;
					oe_d    = 1'b0;
					case (st_q)
						D_CTRL: begin
							if (rnw_q) begin
								st_d  = D_READ;
								shr_d = rd_byte;
								oe_d  = ~rd_byte[BYTE_W-1];
							end else begin
								st_d = D_AH;
							end
						end
						D_AH:    st_d = D_AL;
						D_AL:    st_d = D_WDATA;
						D_WDATA: st_d = D_WDATA;
						D_READ: begin
							if (!ackin_q) begin
								shr_d = rd_byte;
								oe_d  = ~rd_byte[BYTE_W-1];
							end else begin
								st_d = D_IDLE;
							end
						end
						default: st_d = D_IDLE;
					endcase
				end
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			st_q      <= D_IDLE;
			bitn_q    <= '0;
			ackph_q   <= 1'b0;
			ackin_q   <= 1'b1;
			rnw_q     <= 1'b0;
			shr_q     <= '0;
			oe_q      <= 1'b0;
			ptr_q     <= '0;
			ahi_q     <= '0;
			wbuf_q    <= '0;
			waddr_q   <= '0;
			wpend_q   <= 1'b0;
			busy_q    <= '0;
			wr_busy_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			bitn_q    <= bitn_d;
			ackph_q   <= ackph_d;
			ackin_q   <= ackin_d;
			rnw_q     <= rnw_d;
			shr_q     <= shr_d;
			oe_q      <= oe_d;
			ptr_q     <= ptr_d;
			ahi_q     <= ahi_d;
			wbuf_q    <= wbuf_d;
			waddr_q   <= waddr_d;
			wpend_q   <= wpend_d;
			busy_q    <= busy_d;
			wr_busy_q <= (busy_d != '0);
		end
	end

	// array is not reset: contents survive like the real cells
	always_ff @(posedge link_clk) begin
		if (mem_we) begin
			mem_q[waddr_q] <= wbuf_q;
		end
	end

	assign link.dev_sda_oe = oe_q;
	assign link.dev_sda_o  = 1'b0;
endmodule
`default_nettype wire

// ==== eep_host.sv ====
// Purpose: two-wire controller issuing writes, polls and reads
// Assumes: clk_sys at 10 MHz, scl made by a divider
// Notes:   poll retries with repeated Start until acked
`timescale 1ns/1ps
`default_nettype none
module eep_host import eep_pkg::*; (
	eep_link_if.host        link,
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       cmd_valid,
	input  wire eep_op_e    cmd_op,
	input  wire logic [2:0] cmd_chip,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [BYTE_W-1:0] cmd_wdata,
	input  wire logic [7:0] cmd_len,
	output logic            cmd_ready_q,
	output logic [BYTE_W-1:0] rd_data_q,
	output logic            rd_valid_q,
	output logic            done_q,
	output logic            nacked_q
);
	localparam int QTR_CYC = BIT_TIME_NS / (QTRS * CLK_SYS_NS);
	localparam int DIV_W   = $clog2(QTR_CYC);

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BYTE  = 2'b10,
		H_STOP  = 2'b11
	} eep_hst_e;

	typedef enum logic [2:0] {
		S_CTRLW = 3'b000,
		S_AH    = 3'b001,
		S_AL    = 3'b010,
		S_WDATA = 3'b011,
		S_CTRLR = 3'b100,
		S_RD    = 3'b101
	} eep_seg_e;

	eep_hst_e          st_q, st_d;
	eep_seg_e          seg_q, seg_d;
	eep_op_e           op_q, op_d;
	logic [1:0]        sub_q, sub_d;
	logic [DIV_W-1:0]  div_q, div_d;
	logic [3:0]        bitn_q, bitn_d;
	logic [BYTE_W-1:0] shr_q, shr_d;
	logic              ackin_q, ackin_d;
	logic [2:0]        chip_q, chip_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [BYTE_W-1:0] wdata_q, wdata_d;
	logic [7:0]        len_q, len_d;
	logic              scl_q, scl_d, oe_q, oe_d;
	logic              rdy_d, rdv_d, done_d, nack_d;
	logic [BYTE_W-1:0] rdd_d;
	logic              sda_s1_q, sda_s2_q, sda_s3_q, sda_f_q;
	logic              tick;

	// byte put on the wire for each segment
	function automatic logic [BYTE_W-1:0] seg_byte(input eep_seg_e s);
		case (s)
			S_CTRLW: seg_byte = {TYPE_CODE, chip_q, 1'b0};
			S_CTRLR: seg_byte = {TYPE_CODE, chip_q, 1'b1};
			S_AH:    seg_byte = {AH_PAD, addr_q[ADDR_W-1:BYTE_W]};
			S_AL:    seg_byte = addr_q[BYTE_W-1:0];
			S_WDATA: seg_byte = wdata_q;
			default: seg_byte = '1;
		endcase
	endfunction

	assign tick = (div_q == DIV_W'(QTR_CYC - 1));

	always_comb begin
		st_d = st_q; seg_d = seg_q; op_d = op_q; sub_d = sub_q;
		bitn_d = bitn_q; shr_d = shr_q; ackin_d = ackin_q;
		chip_d = chip_q; addr_d = addr_q; wdata_d = wdata_q; len_d = len_q;
		scl_d = scl_q; oe_d = oe_q; rdd_d = rd_data_q;
		rdy_d = cmd_ready_q; rdv_d = 1'b0; done_d = 1'b0; nack_d = nacked_q;
		div_d = tick ? '0 : div_q + DIV_W'(1);
		if (st_q == H_IDLE) begin
			div_d = '0;
			sub_d = Q_LOW;
			// idle means ready, so the port opens on the first edge after reset
			rdy_d = 1'b1;
			if (cmd_valid && cmd_ready_q) begin
				op_d = cmd_op; chip_d = cmd_chip; addr_d = cmd_addr;
				wdata_d = cmd_wdata; len_d = cmd_len;
				rdy_d = 1'b0; nack_d = 1'b0;
				seg_d = (cmd_op == OP_RD_CUR) ? S_CTRLR : S_CTRLW;
				st_d = H_START;
			end
		end else if (tick) begin
			sub_d = sub_q + 2'h1;
			case (st_q)
				H_START: begin
					// works as both first and repeated Start
					case (sub_q)
						Q_LOW:  begin scl_d = 1'b0; oe_d = 1'b0; end
						Q_RISE: scl_d = 1'b1;
						Q_MID:  oe_d = 1'b1;
						default: begin
							scl_d = 1'b0; st_d = H_BYTE; bitn_d = '0;
							shr_d = seg_byte(seg_q);
						end
					endcase
				end
				H_BYTE: begin
					case (sub_q)
						Q_LOW: begin
							scl_d = 1'b0;
							if (bitn_q < BIT_ACK)
								oe_d = (seg_q != S_RD) & ~shr_q[BYTE_W-1];
							else
								// ack each byte but the last read
								oe_d = (seg_q == S_RD) && (len_q != 8'h01);
						end
						Q_RISE: scl_d = 1'b1;
						Q_MID: begin
							if (bitn_q < BIT_ACK) shr_d = {shr_q[BYTE_W-2:0], sda_f_q};
							else ackin_d = sda_f_q;
						end
						default: begin
							scl_d = 1'b0;
							if (bitn_q < BIT_ACK) bitn_d = bitn_q + 4'h1;
							else if (seg_q == S_RD) begin
								rdd_d = shr_q; rdv_d = 1'b1; bitn_d = '0;
								if (len_q == 8'h01) st_d = H_STOP;
								else len_d = len_q - 8'h01;
							end else if (ackin_q) begin
								// busy device: a poll sends Start and control again, other ops stop
								if (op_q == OP_POLL) st_d = H_START;
								else begin nack_d = 1'b1; st_d = H_STOP; end
							end else begin
								bitn_d = '0;
								case (seg_q)
									S_CTRLW: if (op_q == OP_POLL) st_d = H_STOP;
										else seg_d = S_AH;
									S_AH:    seg_d = S_AL;
									S_AL:    if (op_q == OP_RD_RAND) begin
											seg_d = S_CTRLR; st_d = H_START;
										end else seg_d = S_WDATA;
									S_CTRLR: seg_d = S_RD;
									default: st_d = H_STOP;
								endcase
								shr_d = seg_byte(seg_d);
							end
						end
					endcase
				end
				default: begin
					case (sub_q)
						Q_LOW:  begin scl_d = 1'b0; oe_d = 1'b1; end
						Q_RISE: scl_d = 1'b1;
						Q_MID:  oe_d = 1'b0;
						default: begin st_d = H_IDLE; done_d = 1'b1; rdy_d = 1'b1; end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_q <= H_IDLE; seg_q <= S_CTRLW; op_q <= OP_WRITE; sub_q <= Q_LOW;
			div_q <= '0; bitn_q <= '0; shr_q <= '0; ackin_q <= 1'b1;
			chip_q <= '0; addr_q <= '0; wdata_q <= '0; len_q <= '0;
			scl_q <= 1'b1; oe_q <= 1'b0; rd_data_q <= '0; cmd_ready_q <= 1'b0;
			rd_valid_q <= 1'b0; done_q <= 1'b0; nacked_q <= 1'b0;
			sda_s1_q <= 1'b1; sda_s2_q <= 1'b1; sda_s3_q <= 1'b1; sda_f_q <= 1'b1;
		end else begin
			st_q <= st_d; seg_q <= seg_d; op_q <= op_d; sub_q <= sub_d;
			div_q <= div_d; bitn_q <= bitn_d; shr_q <= shr_d; ackin_q <= ackin_d;
			chip_q <= chip_d; addr_q <= addr_d; wdata_q <= wdata_d; len_q <= len_d;
			scl_q <= scl_d; oe_q <= oe_d; rd_data_q <= rdd_d; cmd_ready_q <= rdy_d;
			rd_valid_q <= rdv_d; done_q <= done_d; nacked_q <= nack_d;
			sda_s1_q <= link.sda; sda_s2_q <= sda_s1_q; sda_s3_q <= sda_s2_q;
			if (sda_s2_q == sda_s3_q) sda_f_q <= sda_s2_q;
		end
	end

	assign link.scl         = scl_q;
	assign link.host_sda_oe = oe_q;
	assign link.host_sda_o  = 1'b0;
endmodule
`default_nettype wire

// ==== eep_link_sva.sv ====
// Purpose: link checks for the eeprom pair
// Assumes: link_clk far faster than scl
// Notes:   raw wire levels sampled on link_clk
`timescale 1ns/1ps
`default_nettype none
module eep_link_sva import eep_pkg::*; #(
	parameter int WR_CYC = WR_CYC_DEF
) (
	input wire logic link_clk,
	input wire logic link_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic host_sda_o,
	input wire logic dev_sda_oe,
	input wire logic dev_sda_o,
	input wire logic wr_busy_q,
	input wire logic write_protect_pin
);
	// ************************
	// helper state
	// ************************
	// device filters the wire, so stop timing allows a few cycles of slack
	logic        scl_q, sda_q, started_q, started_d, stop_ev, start_ev;
	logic [4:0]  stop_age_q, stop_age_d;
	logic [31:0] busy_cnt_q, busy_cnt_d;
	always_comb begin
		stop_ev    = scl & scl_q & sda & ~sda_q;
		start_ev   = scl & scl_q & ~sda & sda_q;
		started_d  = started_q | start_ev;
		stop_age_d = stop_ev ? 5'h0 : stop_age_q + {4'h0, ~&stop_age_q};
		busy_cnt_d = wr_busy_q ? busy_cnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge link_clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (link_rst) begin
			started_q  <= 1'b0;
			stop_age_q <= 5'h1f;
			busy_cnt_q <= 32'h0;
		end else begin
			started_q  <= started_d;
			stop_age_q <= stop_age_d;
			busy_cnt_q <= busy_cnt_d;
		end
	end
	// ************************
	// properties
	// ************************
	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (link_rst);
	// the wire itself must read low whenever either end claims it
	property p_oe_low_only; dev_sda_oe |-> !dev_sda_o && !sda; endproperty
	a_oe_low_only: assert property (p_oe_low_only) else $error("data driven high");
	property p_host_low_only; host_sda_oe |-> !host_sda_o && !sda; endproperty
	a_host_low_only: assert property (p_host_low_only) else $error("host drove high");
	property p_no_ack_busy; wr_busy_q |-> !$rose(dev_sda_oe); endproperty
	a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while busy");
	property p_oe_stable_hi; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
	a_oe_stable_hi: assert property (p_oe_stable_hi) else $error("data moved, clock high");
	property p_oe_turn_low; $changed(dev_sda_oe) |-> !scl; endproperty
	a_oe_turn_low: assert property (p_oe_turn_low) else $error("data turn, clock high");
	property p_busy_at_stop; $rose(wr_busy_q) |-> stop_age_q < 5'h10; endproperty
	a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy not at stop");
	property p_busy_len; $fell(wr_busy_q) |-> busy_cnt_q inside {[WR_CYC-12:WR_CYC+2]}; endproperty
	a_busy_len: assert property (p_busy_len) else $error("write time wrong");
	property p_wp_no_busy; $rose(wr_busy_q) |-> !write_protect_pin; endproperty
	a_wp_no_busy: assert property (p_wp_no_busy) else $error("protected write ran");
	property p_oe_after_start; $rose(dev_sda_oe) |-> started_q; endproperty
	a_oe_after_start: assert property (p_oe_after_start) else $error("drive before start");
	c_busy: cover property ($rose(wr_busy_q));
	c_ack: cover property ($rose(dev_sda_oe));
	c_start: cover property (start_ev);
endmodule
`default_nettype wire

// ==== serial_eeprom_read_and_poll_tb.sv ====
// Purpose: end to end bench of host and eeprom ends
// Assumes: write time twenty times the default so a read lands while busy
// Notes:   random strap and data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_and_poll_tb;
	import eep_pkg::*;
	localparam int WRC = 20000;
	logic              clk_sys, srst, link_clk, link_rst, cmd_valid, wp, nk;
	logic              cmd_ready_q, rd_valid_q, done_q, nacked_q, wr_busy_q;
	eep_op_e           cmd_op;
	logic [2:0]        cmd_chip, strap;
	logic [ADDR_W-1:0] cmd_addr;
	logic [BYTE_W-1:0] cmd_wdata, rd_data_q;
	logic [7:0]        cmd_len;
	logic [BYTE_W-1:0] got [$];
	logic [BYTE_W-1:0] mm [int];
	int                errors, comparisons, seed;
	eep_link_if link ();
	eep_host u_eep_host (.link(link.host), .clk_sys(clk_sys), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chip(cmd_chip), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .cmd_ready_q(cmd_ready_q),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .done_q(done_q), .nacked_q(nacked_q));
	eep_dev #(.WR_CYC(WRC)) u_eep_dev (.link(link.dev), .link_clk(link_clk),
		.link_rst(link_rst), .chip_addr_bit0(strap[0]), .chip_addr_bit1(strap[1]),
		.chip_addr_bit2(strap[2]), .write_protect_pin(wp), .wr_busy_q(wr_busy_q));
	eep_link_sva #(.WR_CYC(WRC)) u_eep_link_sva (.link_clk(link_clk), .link_rst(link_rst),
		.scl(link.scl), .sda(link.sda), .host_sda_oe(link.host_sda_oe),
		.host_sda_o(link.host_sda_o), .dev_sda_oe(link.dev_sda_oe),
		.dev_sda_o(link.dev_sda_o), .wr_busy_q(wr_busy_q), .write_protect_pin(wp));
	// ************************
	// clocks
	// ************************
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	// ************************
	// tasks
	// ************************
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic tick(inout int k);
		@(negedge clk_sys);
		k++;
		if (k > 30000) begin
			check(1'b0, "wait ran out");
			report_and_stop();
		end
	endtask
	// one command, held until taken, then bytes gathered until done
	task automatic run(input eep_op_e op, input logic [2:0] ch, input logic [12:0] a,
		input logic [7:0] d, input logic [7:0] n);
		int k;
		k = 0;
		got.delete();
		tick(k);
		while (cmd_ready_q !== 1'b1)
			tick(k);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_chip = ch;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_len = n;
		tick(k);
		cmd_valid = 1'b0;
		while (done_q !== 1'b1) begin
			tick(k);
			if (rd_valid_q === 1'b1)
				got.push_back(rd_data_q);
		end
		nk = nacked_q;
		if (op == OP_WRITE && !wp)
			mm[a] = d;
	endtask
	// expected bytes walk the model from a, wrapping at the top
	function automatic logic seq_ok(input int a, input int n);
		seq_ok = (got.size() == n);
		for (int i = 0; i < n && seq_ok; i++) begin
			seq_ok = (got[i] === mm[a]);
			a = (a + 1) % MEM_DEPTH;
		end
	endfunction
	// ************************
	// main sequence
	// ************************
	initial begin
		seed = 32'hec06_fe13;
		errors = 0;
		comparisons = 0;
		cmd_valid = 1'b0;
		cmd_op = OP_WRITE;
		cmd_chip = 3'h0;
		cmd_addr = 13'h0;
		cmd_wdata = 8'h00;
		cmd_len = 8'h01;
		wp = 1'b0;
		srst = 1'b1;
		link_rst = 1'b1;
		strap = 3'($random(seed));
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 1'b0;
		link_rst = 1'b0;
		run(OP_WRITE, strap, 13'h1fff, 8'($random(seed)), 8'h01);
		check(wr_busy_q === 1'b1, "no busy after stop");
		run(OP_RD_CUR, strap, 13'h0, 8'h00, 8'h01);
		check(nk === 1'b1 && got.size() == 0, "read taken while busy");
		run(OP_POLL, strap, 13'h0, 8'h00, 8'h01);
		check(wr_busy_q === 1'b0 && nk === 1'b0, "poll end wrong");
		$display("test busy_poll done");
		for (int i = 0; i < 2; i++) begin
			run(OP_WRITE, strap, 13'(i), 8'($random(seed)), 8'h01);
			run(OP_POLL, strap, 13'h0, 8'h00, 8'h01);
			check(wr_busy_q === 1'b0 && nk === 1'b0, "poll retry end wrong");
		end
		run(OP_RD_RAND, strap, 13'h1fff, 8'h00, 8'h02);
		check(seq_ok(32'h1fff, 2), "wrapped sequence wrong");
		run(OP_RD_CUR, strap, 13'h0, 8'h00, 8'h01);
		check(seq_ok(1, 1), "current after random wrong");
		$display("test reads done");
		wp = 1'b1;
		run(OP_WRITE, strap, 13'h0, ~mm[0], 8'h01);
		check(wr_busy_q === 1'b0 && nk === 1'b0, "protected write busy");
		wp = 1'b0;
		run(OP_RD_RAND, strap, 13'h0, 8'h00, 8'h01);
		check(seq_ok(0, 1), "protected data changed");
		$display("test protect done");
		for (int b = 0; b < 3; b++) begin
			run(OP_RD_CUR, strap ^ 3'(1 << b), 13'h0, 8'h00, 8'h01);
			check(nk === 1'b1 && got.size() == 0, "foreign select answered");
		end
		run(OP_RD_CUR, strap, 13'h0, 8'h00, 8'h01);
		check(seq_ok(1, 1), "pointer moved on mismatch");
		$display("test select done");
		report_and_stop();
	end
endmodule
`default_nettype wire
